//--- rtl/sps_pkg.sv
// Package with constants and carrier types for the setpoint source switch.
package sps_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int VAL_W = 16;

    // ------------------------------------------------------------------
    // APB register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CFG    = 8'h00;
    localparam logic [7:0] OFF_WI     = 8'h04;
    localparam logic [7:0] OFF_SH     = 8'h08;
    localparam logic [7:0] OFF_SES    = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_ACTIVE = 8'h14;
    localparam logic [7:0] OFF_EXT    = 8'h18;

    // ------------------------------------------------------------------
    // Configuration field positions
    // ------------------------------------------------------------------
    localparam int CFG_KEY_LSB   = 0;  // key_force_sw, 2 bits.
    localparam int CFG_READY_LSB = 2;  // ready_force_sw, 4 bits.
    localparam int CFG_SRC_LSB   = 6;  // ext_source_select_sw, 3 bits.
    localparam int CFG_FAIL_BIT  = 9;  // failure_target_sw.
    localparam int CFG_SUPP_BIT  = 10; // tracking_suppress_sw.
    localparam int CFG_TRKX_BIT  = 11; // track_to_actual_sw.
    localparam int CFG_ACK_BIT   = 12; // ready_ack_sw.
    localparam int CFG_DISP_LSB  = 13; // display_order_sw, 2 bits.
    localparam int CFG_W         = 15;

    // ------------------------------------------------------------------
    // Reset values and switch encodings
    // ------------------------------------------------------------------
    localparam logic [CFG_W-1:0] CFG_RST = 15'h0020; // Key forced 1, ready forced 1.
    localparam logic [1:0] KEY_FORCE_ONE  = 2'h0;
    localparam logic [1:0] KEY_FORCE_ZERO = 2'h1;
    localparam logic [1:0] KEY_FOLLOW     = 2'h2;
    localparam logic [3:0] READY_FORCE_ZERO = 4'h0;
    localparam logic [3:0] READY_FORCE_ONE  = 4'h8;
    localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
    localparam logic [2:0] SRC_SERIAL_A = 3'h2;
    localparam logic [2:0] SRC_SERIAL_B = 3'h3;

    // ------------------------------------------------------------------
    // Ramp step per controller cycle
    // ------------------------------------------------------------------
    localparam logic [VAL_W-1:0] RAMP_STEP = 16'h0010;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SRC_INT  = 4'b0001,
        SRC_EXT  = 4'b0010,
        SRC_SAFE = 4'b0100,
        SRC_X    = 4'b1000
    } sps_src_t;

    typedef struct packed {
        logic [VAL_W-1:0] active;
        logic [VAL_W-1:0] display;
        logic             lamp_x;
        logic             lamp_w;
    } sps_view_t;
endpackage

//--- rtl/sps_setpoint_switch.sv
// Setpoint source selection with tracking, failure handling and display.
// Functional notes
// - Computer operation is inverted key state AND computer-ready; selects external.
// - During computer operation the external path gives the active setpoint.
// - Selector 0,1,4,5 picks analog input; 2,3 picks serial value.
// - On ready falling, adopt tracked computer setpoint or safety setpoint.
// - Key state and ready can each be forced statically to 1 or 0.
// - Default forcing keeps the internal setpoint active, no switching.
// - Switching can follow only the key or only the ready input.
// - Key forced 0 with ready forced 1 locks external follower operation.
// - Shift key steps display: III external, IV main variable, I active.
// - Two lamps mark display levels I (lamp_w) and IV (lamp_x); both are dark at II and III.
// - Suppression switch stops inactive setpoints following the active one.
// - Internal case: tracked internal setpoint, both messages 1, internal lamp.
// - Request active with track-to-actual set makes actual value active.
// - Safety setpoint only from external on ready fall; key fall keeps internal.
// - Safety setpoint is never tracked; moves go through the ramp.
// - Serial external setpoint is tracked; analog external is not.
// - Messages are gated off by manual, tracking or safety requests.
// - Tracked setpoint loads value active before changeover, no step.
// - Behaviour is static ready switching without acknowledgement.
module sps_setpoint_switch (
    input  wire logic                     pclk,               // APB clock.
    input  wire logic                     presetn,            // Async reset, low.
    input  wire logic                     psel,               // APB select.
    input  wire logic                     penable,            // APB enable.
    input  wire logic                     pwrite,             // APB write.
    input  wire logic [7:0]               paddr,              // APB byte address.
    input  wire logic [31:0]              pwdata,             // APB write data.
    output logic      [31:0]              prdata,             // APB read data.
    output logic                          pready,             // APB ready.
    output logic                          pslverr,            // APB error.
    input  wire logic                     cycle_tick,         // Controller cycle strobe.
    input  wire logic                     computer_ready_in,  // Ready pin.
    input  wire logic                     internal_key_in,    // Internal/external key pulse.
    input  wire logic                     shift_key_in,       // Display shift key pulse.
    input  wire logic                     mode_request_in,    // Manual/tracking/safety OR.
    input  wire logic [15:0]              analog_external_setpoint, // Analog input.
    input  wire logic [15:0]              actual_value,       // Actual value x.
    input  wire logic [15:0]              main_controlled_var,// Main variable.
    output logic                          computer_operation_out, // Operation message.
    output logic                          computer_standby_out,   // Standby message.
    output logic                          internal_lamp,      // Internal lamp.
    output logic                          computer_lamp,      // Computer lamp.
    output logic      [15:0]              active_setpoint,    // Ramped active setpoint.
    output logic      [15:0]              display_value,      // Setpoint display.
    output logic                          lamp_x,             // Actual-value lamp.
    output logic                          lamp_w              // Setpoint lamp.
);
    localparam int W = sps_pkg::VAL_W;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic       key_prev_q;
    logic       shift_prev_q;

    // Two flops for every asynchronous control pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {cycle_tick, computer_ready_in, internal_key_in,
                        shift_key_in, mode_request_in};
            sync2_q <= sync1_q;
        end
    end

    wire tick_s  = sync2_q[4];
    wire ready_s = sync2_q[3];
    wire key_s   = sync2_q[2];
    wire shift_s = sync2_q[1];
    wire req_s   = sync2_q[0];

    // ------------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------------
    logic [sps_pkg::CFG_W-1:0] cfg_q;
    logic [W-1:0]              wi_q;
    logic [W-1:0]              sh_q;
    logic [W-1:0]              ses_q;

    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire hit_cfg = paddr == sps_pkg::OFF_CFG;
    wire hit_wi  = paddr == sps_pkg::OFF_WI;
    wire hit_sh  = paddr == sps_pkg::OFF_SH;
    wire hit_ses = paddr == sps_pkg::OFF_SES;
    wire hit_st  = paddr == sps_pkg::OFF_STATUS;
    wire hit_act = paddr == sps_pkg::OFF_ACTIVE;
    wire hit_ext = paddr == sps_pkg::OFF_EXT;
    wire mapped  = hit_cfg | hit_wi | hit_sh | hit_ses | hit_st | hit_act | hit_ext;

    wire [1:0] key_sw   = cfg_q[sps_pkg::CFG_KEY_LSB +: 2];
    wire [3:0] ready_sw = cfg_q[sps_pkg::CFG_READY_LSB +: 4];
    wire [2:0] src_sw   = cfg_q[sps_pkg::CFG_SRC_LSB +: 3];
    wire       fail_sw  = cfg_q[sps_pkg::CFG_FAIL_BIT];
    wire       supp_sw  = cfg_q[sps_pkg::CFG_SUPP_BIT];
    wire       trkx_sw  = cfg_q[sps_pkg::CFG_TRKX_BIT];
    wire [1:0] disp_sw  = cfg_q[sps_pkg::CFG_DISP_LSB +: 2];

    // ------------------------------------------------------------------
    // Forcing of key state and ready
    // ------------------------------------------------------------------
    logic       int_key_q;
    logic       ready_prev_q;
    wire key_edge   = key_s & ~key_prev_q;
    wire key_state  = (key_sw == sps_pkg::KEY_FORCE_ONE)  ? 1'b1 :
                      (key_sw == sps_pkg::KEY_FORCE_ZERO) ? 1'b0 :
                      int_key_q;
    wire ready_eff  = (ready_sw == sps_pkg::READY_FORCE_ONE)  ? 1'b1 :
                      (ready_sw == sps_pkg::READY_FORCE_ZERO) ? 1'b0 :
                      ready_s;
    wire comp_op    = ~key_state & ready_eff;
    wire ready_fall = ready_prev_q & ~ready_eff;

    // External source selection.
    wire          use_serial = (src_sw == sps_pkg::SRC_SERIAL_A) |
                               (src_sw == sps_pkg::SRC_SERIAL_B);
    wire [W-1:0]  ext_val    = use_serial ? ses_q : analog_external_setpoint;

    // ------------------------------------------------------------------
    // Source state machine
    // ------------------------------------------------------------------
    sps_pkg::sps_src_t src_q;
    sps_pkg::sps_src_t src_d;
    sps_pkg::sps_src_t base_d;

    // Base source: computer operation picks external, else internal or safety.
    always_comb begin
        base_d = src_q;
        if (comp_op) begin
            base_d = sps_pkg::SRC_EXT;
        end else if (ready_fall && src_q == sps_pkg::SRC_EXT && fail_sw) begin
            base_d = sps_pkg::SRC_SAFE;
        end else if (src_q == sps_pkg::SRC_SAFE && !key_state) begin
            base_d = sps_pkg::SRC_SAFE;
        end else begin
            base_d = sps_pkg::SRC_INT;
        end
        src_d = (req_s && trkx_sw) ? sps_pkg::SRC_X : base_d;
    end

    // Target value of each source.
    logic [W-1:0] target;
    always_comb begin
        unique case (src_q)
            sps_pkg::SRC_INT:  target = wi_q;
            sps_pkg::SRC_EXT:  target = ext_val;
            sps_pkg::SRC_SAFE: target = sh_q;
            sps_pkg::SRC_X:    target = actual_value;
            default:           target = wi_q;
        endcase
    end

    // Ramp toward the target for every source change, safety included.
    logic [W-1:0] act_q;
    wire [W:0]    up_sum  = {1'b0, act_q} + {1'b0, sps_pkg::RAMP_STEP};
    wire [W:0]    dn_diff = {1'b0, act_q} - {1'b0, sps_pkg::RAMP_STEP};
    wire          near    = (target > act_q) ? (target - act_q <= sps_pkg::RAMP_STEP)
                                             : (act_q - target <= sps_pkg::RAMP_STEP);
    wire [W-1:0]  act_d   = near ? target :
                            (target > act_q) ? up_sum[W-1:0] : dn_diff[W-1:0];

    // Tracking: the internal and serial setpoints follow the active one while inactive, unless suppressed.
    wire changing  = src_d != src_q;
    wire trk_en    = ~supp_sw;
    wire wi_track  = trk_en & (src_q != sps_pkg::SRC_INT);
    // The serial value follows unless it is the source in use, so a later move to it is bumpless.
    wire ses_track = trk_en & ~(use_serial & (src_q == sps_pkg::SRC_EXT));

    // ------------------------------------------------------------------
    // Display levels
    // ------------------------------------------------------------------
    logic [1:0] level_q;
    wire        shift_edge = shift_s & ~shift_prev_q;
    wire        lvl3_ok    = disp_sw[0];
    wire        lvl4_ok    = disp_sw[1];
    logic [1:0] level_next;
    always_comb begin
        unique case (level_q)
            2'h0:    level_next = 2'h1;
            2'h1:    level_next = lvl3_ok ? 2'h2 : (lvl4_ok ? 2'h3 : 2'h0);
            2'h2:    level_next = lvl4_ok ? 2'h3 : 2'h0;
            default: level_next = 2'h0;
        endcase
    end
    sps_pkg::sps_view_t view_d;
    always_comb begin
        view_d.active = act_d;
        unique case (level_q)
            2'h0:    view_d.display = act_q;
            2'h1:    view_d.display = actual_value;
            2'h2:    view_d.display = ext_val;
            default: view_d.display = main_controlled_var;
        endcase
        view_d.lamp_x = (level_q == 2'h3);
        view_d.lamp_w = (level_q == 2'h0);
    end

    // ------------------------------------------------------------------
    // Clocked state
    // ------------------------------------------------------------------
    // Register writes by APB; hardware tracking wins over a software write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= sps_pkg::CFG_RST;
            wi_q  <= sps_pkg::VAL_RST;
            sh_q  <= sps_pkg::VAL_RST;
            ses_q <= sps_pkg::VAL_RST;
        end else begin
            if (wr && hit_cfg) cfg_q <= pwdata[sps_pkg::CFG_W-1:0];
            if (wr && hit_sh)  sh_q  <= pwdata[W-1:0];
            if (tick_s && wi_track) wi_q <= act_q;
            else if (wr && hit_wi) wi_q <= pwdata[W-1:0];
            if (tick_s && ses_track) ses_q <= act_q;
            else if (wr && hit_ses) ses_q <= pwdata[W-1:0];
        end
    end

    // Per-cycle selection, edge memories and display.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q        <= sps_pkg::SRC_INT;
            act_q        <= sps_pkg::VAL_RST;
            int_key_q    <= 1'b1;
            ready_prev_q <= 1'b1;
            key_prev_q   <= 1'b0;
            shift_prev_q <= 1'b0;
            level_q      <= 2'h0;
        end else begin
            key_prev_q   <= key_s;
            shift_prev_q <= shift_s;
            if (key_edge) int_key_q <= ~int_key_q;
            if (shift_edge) level_q <= level_next;
            if (tick_s) begin
                src_q        <= src_d;
                act_q        <= act_d;
                ready_prev_q <= ready_eff;
            end
        end
    end

    // Registered outputs.
    wire ops_d = comp_op & ~req_s;
    wire sby_d = key_state & ~req_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            computer_operation_out <= 1'b0;
            computer_standby_out   <= 1'b0;
            internal_lamp          <= 1'b1;
            computer_lamp          <= 1'b0;
            active_setpoint        <= sps_pkg::VAL_RST;
            display_value          <= sps_pkg::VAL_RST;
            lamp_x                 <= 1'b0;
            lamp_w                 <= 1'b1;
        end else begin
            if (tick_s) begin
                computer_operation_out <= ops_d | sby_d;
                computer_standby_out   <= sby_d;
                internal_lamp          <= key_state;
                computer_lamp          <= ~ready_eff;
                active_setpoint        <= view_d.active;
            end
            display_value <= view_d.display;
            lamp_x        <= view_d.lamp_x;
            lamp_w        <= view_d.lamp_w;
        end
    end

    // ------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------
    wire [31:0] status_w = {23'h000000, src_q, ready_eff, key_state, comp_op,
                            req_s, computer_standby_out};
    wire [31:0] rd_mux   = hit_cfg ? {17'h00000, cfg_q} :
                           hit_wi  ? {16'h0000, wi_q} :
                           hit_sh  ? {16'h0000, sh_q} :
                           hit_ses ? {16'h0000, ses_q} :
                           hit_st  ? status_w :
                           hit_act ? {16'h0000, act_q} :
                           hit_ext ? {16'h0000, ext_val} : 32'h00000000;

    // No wait state: read data and ready are registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= rd_mux;
            pslverr <= psel & ~penable & ~mapped;
        end
    end
endmodule

//--- verif/sps_far_end.sv
// Behavioural master controller feeding the ready pin and the analog setpoint.
module sps_far_end (
    input  wire logic        pclk,                     // Clock.
    input  wire logic        presetn,                  // Reset, active low.
    input  wire logic        ready_req,                // Bench command for ready.
    input  wire logic [15:0] level_req,                // Bench command for setpoint.
    output logic             computer_ready_in,        // Static ready level.
    output logic      [15:0] analog_external_setpoint  // Analog setpoint value.
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ready is a static level with no acknowledge; values change just after an edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            computer_ready_in <= 1'b0;
            analog_external_setpoint <= 16'h0000;
        end else begin
            computer_ready_in <= ready_req;
            analog_external_setpoint <= level_req;
        end
    end
endmodule

//--- verif/sps_setpoint_switch_properties.sv
// Concurrent checks on the ports of the setpoint switch.
module sps_setpoint_switch_checker (
    input wire logic        pclk,                   // Clock.
    input wire logic        presetn,                // Reset, active low.
    input wire logic        psel,                   // Select.
    input wire logic        penable,                // Enable.
    input wire logic        pwrite,                 // Direction.
    input wire logic [31:0] prdata,                 // Read data.
    input wire logic        pready,                 // Ready.
    input wire logic        pslverr,                // Error.
    input wire logic        cycle_tick,             // Cycle strobe.
    input wire logic        computer_operation_out, // Operation message.
    input wire logic        computer_standby_out,   // Standby message.
    input wire logic        internal_lamp,          // Internal lamp.
    input wire logic [15:0] active_setpoint,        // Active setpoint.
    input wire logic [15:0] display_value,          // Display value.
    input wire logic        lamp_x,                 // Actual-value lamp.
    input wire logic        lamp_w                  // Setpoint lamp.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  since_q;
    logic [15:0] prev_q;
    logic [15:0] step;
    // Counts cycles since the last tick so message changes can be paced.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_q <= 4'h0;
            prev_q <= 16'h0000;
        end else begin
            since_q <= cycle_tick ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
            prev_q <= active_setpoint;
        end
    end
    // Size of the last change of the active setpoint.
    assign step = (active_setpoint > prev_q) ? active_setpoint - prev_q : prev_q - active_setpoint;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready in the access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("refused read returned data");
    tick_paced_a: assert property ($changed(computer_operation_out) |-> since_q <= 4'h6)
        else $error("message changed without a tick");
    standby_lamp_a: assert property (computer_standby_out |-> internal_lamp && computer_operation_out)
        else $error("standby without internal lamp and operation");
    lamps_apart_a: assert property (!(lamp_x && lamp_w))
        else $error("both display lamps lit");
    level_one_a: assert property (lamp_w && $past(lamp_w) && $stable(active_setpoint) &&
        active_setpoint == $past(active_setpoint, 2) |-> display_value == active_setpoint)
        else $error("level one does not show the active setpoint");
    ramp_step_a: assert property ($changed(active_setpoint) |-> step <= sps_pkg::RAMP_STEP)
        else $error("active setpoint stepped beyond the ramp");
endmodule
bind sps_setpoint_switch sps_setpoint_switch_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cycle_tick(cycle_tick), .computer_operation_out(computer_operation_out),
    .computer_standby_out(computer_standby_out), .internal_lamp(internal_lamp),
    .active_setpoint(active_setpoint), .display_value(display_value), .lamp_x(lamp_x),
    .lamp_w(lamp_w));

//--- verif/tb_top.sv
// Self-checking testbench for the setpoint switch.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cycle_tick;
    logic        ready_req, ready_pin, key_in, shift_in, req_in, op_out, sb_out;
    logic        int_lamp, c_lamp, lamp_x, lamp_w, kprev;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] level, ext_pin, actual, active, disp;
    logic [2:0]  sel [6] = '{3'h2, 3'h0, 3'h1, 3'h4, 3'h5, 3'h3};
    int          n_mismatch = 0;
    int          checks_done = 0;
    sps_far_end far (.pclk(pclk), .presetn(presetn), .ready_req(ready_req), .level_req(level),
        .computer_ready_in(ready_pin), .analog_external_setpoint(ext_pin));
    sps_setpoint_switch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_tick(cycle_tick), .computer_ready_in(ready_pin),
        .internal_key_in(key_in), .shift_key_in(shift_in), .mode_request_in(req_in),
        .analog_external_setpoint(ext_pin), .actual_value(actual),
        .main_controlled_var(16'h0123), .computer_operation_out(op_out),
        .computer_standby_out(sb_out), .internal_lamp(int_lamp), .computer_lamp(c_lamp),
        .active_setpoint(active), .display_value(disp), .lamp_x(lamp_x), .lamp_w(lamp_w));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; ready, read data and error are taken at the same rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 16) begin
                n_mismatch++;
                report_and_stop();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge pclk);
            cycle_tick <= 1'b1;
            @(posedge pclk);
            cycle_tick <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
    task automatic press(input logic shift);
        @(posedge pclk);
        {shift_in, key_in} <= {shift, !shift};
        repeat (4) @(posedge pclk);
        {shift_in, key_in} <= 2'b00;
        repeat (4) @(posedge pclk);
        tick(1);
    endtask
    task automatic source(input sps_pkg::sps_src_t s, input logic [15:0] v);
        apb(1'b0, sps_pkg::OFF_STATUS, 32'h0);
        chk("source", 32'(s), 32'(rd[8:5]));
        chk("active", 32'(v), 32'(active));
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, cycle_tick, key_in, shift_in, req_in} = 8'h00;
        {paddr, pwdata, ready_req, level, actual} = '0;
        repeat (12) @(posedge pclk);
        chk("reset lamps", 32'h28, 32'({int_lamp, c_lamp, lamp_w, lamp_x, op_out, sb_out}));
        presetn <= 1'b1;
        apb(1'b0, sps_pkg::OFF_CFG, 32'h0);
        chk("cfg reset", 32'h20, rd);
        tick(2);
        source(sps_pkg::SRC_INT, 16'h0000);
        chk("messages", 32'hE, 32'({sb_out, op_out, int_lamp, c_lamp}));
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        ready_req <= 1'b1;
        level <= 16'h0030;
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6021);
        tick(5);
        source(sps_pkg::SRC_EXT, 16'h0030);
        chk("computer operation", 32'h1, 32'(rd[2]));
        for (int i = 0; i < 6; i++) begin
            level <= 16'h0030 + 16'(16 * i);
            apb(1'b1, sps_pkg::OFF_CFG, 32'h6021 | (32'(sel[i]) << 6));
            tick(3);
            source(sps_pkg::SRC_EXT, 16'h0030 + 16'(16 * (i == 5 ? 4 : i)));
        end
        apb(1'b1, sps_pkg::OFF_SES, 32'h0090);
        tick(3);
        source(sps_pkg::SRC_EXT, 16'h0090);
        apb(1'b1, sps_pkg::OFF_SH, 32'h0070);
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6205);
        tick(3);
        source(sps_pkg::SRC_EXT, 16'h0080);
        ready_req <= 1'b0;
        tick(3);
        source(sps_pkg::SRC_SAFE, 16'h0070);
        apb(1'b0, sps_pkg::OFF_SH, 32'h0);
        chk("safety value", 32'h70, rd);
        ready_req <= 1'b1;
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6005);
        tick(3);
        ready_req <= 1'b0;
        tick(3);
        source(sps_pkg::SRC_INT, 16'h0080);
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6006);
        tick(1);
        repeat (2) begin
            apb(1'b0, sps_pkg::OFF_STATUS, 32'h0);
            kprev = rd[3];
            press(1'b0);
            apb(1'b0, sps_pkg::OFF_STATUS, 32'h0);
            chk("key state", 32'(!kprev), 32'(rd[3]));
            source(sps_pkg::SRC_INT, 16'h0080);
        end
        actual <= 16'h00A0;
        req_in <= 1'b1;
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6820);
        tick(4);
        source(sps_pkg::SRC_X, 16'h00A0);
        chk("gated messages", 32'h0, 32'({sb_out, op_out}));
        req_in <= 1'b0;
        tick(2);
        chk("messages", 32'hE, 32'({sb_out, op_out, int_lamp, c_lamp}));
        chk("level one", 32'h1, 32'({lamp_x, lamp_w}));
        press(1'b1);
        chk("level two", 32'h0, 32'({lamp_x, lamp_w}));
        press(1'b1);
        chk("level three", 32'h0080, 32'(disp));
        press(1'b1);
        chk("level four", 32'h0123, 32'(disp));
        press(1'b1);
        chk("level one value", 32'h00A0, 32'(disp));
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6421);
        tick(4);
        source(sps_pkg::SRC_EXT, 16'h0080);
        apb(1'b0, sps_pkg::OFF_WI, 32'h0);
        chk("untracked internal", 32'hA0, rd);
        apb(1'b1, sps_pkg::OFF_CFG, 32'h6401);
        tick(4);
        source(sps_pkg::SRC_INT, 16'h00A0);
        report_and_stop();
    end
endmodule
